// ==== cfrs_pkg.sv ====
// cfrs_pkg: constants and types for the field region sequencer
// assumes: used only by cfrs_field_region_sequencer
package cfrs_pkg;
	localparam int unsigned LINE_W = 13;
	localparam int unsigned GRP_W = 5;
	localparam int unsigned REGIONS = 9;
	localparam int unsigned MASKS = 3;
	localparam int unsigned SLOTS = 7;
	localparam int unsigned FNUM_W = 3;
	localparam int unsigned PIX_W = 13;
	// horizontal counter restarts this many pixel clocks after sync falls
	localparam logic [3:0] HSYNC_DELAY = 4'hc;
	localparam logic [15:0] PATTERN_MEM_BASE = 16'h0800;
	localparam logic [LINE_W-1:0] LINE_RESET = 13'h0000;
	localparam logic [PIX_W-1:0] PIX_RESET = 13'h0000;
	localparam logic [FNUM_W-1:0] FNUM_SINGLE = 3'h1;
	localparam logic [2:0] SLOT_FIRST = 3'h0;
	typedef enum logic [1:0] {
		CFRS_ST_IDLE = 2'b00,
		CFRS_ST_WAIT = 2'b01,
		CFRS_ST_RUN = 2'b10
	} cfrs_hstate_t;
endpackage : cfrs_pkg

// ==== cfrs_field_region_sequencer.sv ====
// cfrs_field_region_sequencer: field region, mask and slot sequencer
// assumes: syncs and config inputs synchronous to clk; config held stable
// Function
// - field split into up to nine regions
// - region outputs its chosen pattern group
// - boundary registers 13 bits, line 0-8191
// - pattern select 5 bits, values 0-31
// - clamp start polarity one bit per region
// - 1-bit clamp pattern selector per region
// - three clamp masks suppress clamp pulses
// - blank start polarity one bit per region
// - 1-bit blank pattern selector per region
// - three blank masks suppress blank pulses
// - seven slots each pick field group
// - multi-field starts slot zero, advances per vsync
// - field count 3 bits, one means single
// - pattern group count 5 bits, base 0x800
// - slot select registers 5 bits each
// - masking leaves sequence settings untouched
// - pixel counter zero 12 clocks after sync
`timescale 1ns/100ps
module cfrs_field_region_sequencer #(
	parameter int unsigned NREG = cfrs_pkg::REGIONS,
	parameter int unsigned NMASK = cfrs_pkg::MASKS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// syncs, active high pulses at sync start; hsync is a level
	input wire logic vertical_sync,
	input wire logic horizontal_sync,
	// field registers
	input wire logic [NREG*cfrs_pkg::LINE_W-1:0] region_boundary_line,
	input wire logic [NREG*cfrs_pkg::GRP_W-1:0] region_pattern_select,
	input wire logic [NREG-1:0] clamp_start_polarity,
	input wire logic [NREG-1:0] clamp_pattern_select,
	input wire logic [NMASK*cfrs_pkg::LINE_W-1:0] clamp_mask_start,
	input wire logic [NMASK*cfrs_pkg::LINE_W-1:0] clamp_mask_end,
	input wire logic [NREG-1:0] blank_start_polarity,
	input wire logic [NREG-1:0] blank_pattern_select,
	input wire logic [NMASK*cfrs_pkg::LINE_W-1:0] blank_mask_start,
	input wire logic [NMASK*cfrs_pkg::LINE_W-1:0] blank_mask_end,
	// mode registers
	input wire logic [cfrs_pkg::GRP_W-1:0] pattern_group_count,
	input wire logic [cfrs_pkg::FNUM_W-1:0] applied_field_count,
	input wire logic [cfrs_pkg::SLOTS*cfrs_pkg::GRP_W-1:0] sequence_slot_group,
	// raw toggle levels from the pattern engine
	input wire logic clamp_toggle_raw,
	input wire logic blank_toggle_raw,
	// outputs
	output logic [cfrs_pkg::LINE_W-1:0] line_count,
	output logic [cfrs_pkg::PIX_W-1:0] pixel_count,
	output logic [3:0] region_index,
	output logic [cfrs_pkg::GRP_W-1:0] pattern_group,
	output logic [15:0] pattern_base_addr,
	output logic [2:0] field_slot,
	output logic [cfrs_pkg::GRP_W-1:0] field_group,
	output logic clamp_start_level,
	output logic clamp_pattern,
	output logic blank_start_level,
	output logic blank_pattern,
	output logic black_clamp_pulse,
	output logic pixel_blank_pulse
);
	typedef struct packed {
		logic [1:0] rst_sync;
		logic hs_prev;
		cfrs_pkg::cfrs_hstate_t hst;
		logic [3:0] dly;
		logic [cfrs_pkg::PIX_W-1:0] pix;
		logic [cfrs_pkg::LINE_W-1:0] line;
		logic [3:0] reg_idx;
		logic [2:0] slot;
		logic clamp_out;
		logic blank_out;
	} cfrs_state_t;

	cfrs_state_t s_q;
	cfrs_state_t s_d;
	logic srst_n;
	logic [3:0] region_c;
	logic clamp_masked;
	logic blank_masked;
	logic [cfrs_pkg::LINE_W-1:0] cm_s, cm_e, bm_s, bm_e, bnd;

	assign srst_n = s_q.rst_sync[1];

	always_comb begin
		region_c = 4'h0;
		bnd = cfrs_pkg::LINE_RESET;
		for (int i = 1; i < NREG; i++) begin
			bnd = region_boundary_line[i*cfrs_pkg::LINE_W +: cfrs_pkg::LINE_W];
			if (s_q.line >= bnd && bnd != cfrs_pkg::LINE_RESET) begin
				region_c = 4'(i);
			end
		end
	end

	// clamp mask windows, blank mask windows
	always_comb begin
		clamp_masked = 1'b0;
		blank_masked = 1'b0;
		cm_s = cfrs_pkg::LINE_RESET;
		cm_e = cfrs_pkg::LINE_RESET;
		bm_s = cfrs_pkg::LINE_RESET;
		bm_e = cfrs_pkg::LINE_RESET;
		for (int m = 0; m < NMASK; m++) begin
			cm_s = clamp_mask_start[m*cfrs_pkg::LINE_W +: cfrs_pkg::LINE_W];
			cm_e = clamp_mask_end[m*cfrs_pkg::LINE_W +: cfrs_pkg::LINE_W];
			bm_s = blank_mask_start[m*cfrs_pkg::LINE_W +: cfrs_pkg::LINE_W];
			bm_e = blank_mask_end[m*cfrs_pkg::LINE_W +: cfrs_pkg::LINE_W];
			if (cm_e != cfrs_pkg::LINE_RESET && s_q.line >= cm_s && s_q.line <= cm_e) begin
				clamp_masked = 1'b1;
			end
			if (bm_e != cfrs_pkg::LINE_RESET && s_q.line >= bm_s && s_q.line <= bm_e) begin
				blank_masked = 1'b1;
			end
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
		s_d.hs_prev = horizontal_sync;
		case (s_q.hst)
			cfrs_pkg::CFRS_ST_IDLE: begin
				s_d.pix = s_q.pix + 13'h0001;
				if (s_q.hs_prev && !horizontal_sync) begin
					s_d.hst = cfrs_pkg::CFRS_ST_WAIT;
					s_d.dly = 4'h1;
				end
			end
			cfrs_pkg::CFRS_ST_WAIT: begin
				s_d.pix = s_q.pix + 13'h0001;
				s_d.dly = s_q.dly + 4'h1;
				if (s_q.dly == cfrs_pkg::HSYNC_DELAY - 4'h1) begin
					s_d.pix = cfrs_pkg::PIX_RESET;
					s_d.hst = cfrs_pkg::CFRS_ST_IDLE;
				end
			end
			default: begin
				s_d.hst = cfrs_pkg::CFRS_ST_IDLE;
			end
		endcase
		if (s_q.hs_prev && !horizontal_sync) begin
			s_d.line = s_q.line + 13'h0001;
		end
		s_d.reg_idx = region_c;
		// slot advance on each vertical sync, single field goes to slot 0
		if (vertical_sync) begin
			s_d.line = cfrs_pkg::LINE_RESET;
			if (applied_field_count <= cfrs_pkg::FNUM_SINGLE) begin
				s_d.slot = cfrs_pkg::SLOT_FIRST;
			end else if (s_q.slot >= 3'(applied_field_count - 3'h1)) begin
				s_d.slot = cfrs_pkg::SLOT_FIRST;
			end else begin
				s_d.slot = s_q.slot + 3'h1;
			end
		end
		// masking gates output only, polarity applied
		s_d.clamp_out = !clamp_masked && (clamp_toggle_raw ^ clamp_start_polarity[region_c]);
		s_d.blank_out = !blank_masked && (blank_toggle_raw ^ blank_start_polarity[region_c]);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else if (!srst_n) begin
			s_q <= '0;
			s_q.rst_sync <= {s_q.rst_sync[0], 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	// group chosen by region, 5-bit select
	assign pattern_group = region_pattern_select[s_q.reg_idx*cfrs_pkg::GRP_W +: cfrs_pkg::GRP_W];
	// pattern memory base plus group offset bounded by count
	assign pattern_base_addr = cfrs_pkg::PATTERN_MEM_BASE +
		16'((pattern_group < pattern_group_count) ? pattern_group : 5'h00);
	assign field_group = sequence_slot_group[s_q.slot*cfrs_pkg::GRP_W +: cfrs_pkg::GRP_W];
	assign field_slot = s_q.slot;
	assign line_count = s_q.line;
	assign pixel_count = s_q.pix;
	assign region_index = s_q.reg_idx;
	assign clamp_pattern = clamp_pattern_select[s_q.reg_idx];
	assign blank_pattern = blank_pattern_select[s_q.reg_idx];
	assign clamp_start_level = clamp_start_polarity[s_q.reg_idx];
	assign blank_start_level = blank_start_polarity[s_q.reg_idx];
	assign black_clamp_pulse = s_q.clamp_out;
	assign pixel_blank_pulse = s_q.blank_out;

	sequence s_hs_fall;
		horizontal_sync == 1'b0 && s_q.hs_prev == 1'b1;
	endsequence
	property p_pix_restart;
		@(posedge clk) disable iff (!srst_n)
		(s_q.hst == cfrs_pkg::CFRS_ST_IDLE) and s_hs_fall |-> ##12 pixel_count == 13'h0000;
	endproperty
	a_pix_restart: assert property (p_pix_restart) else $error("pixel count not zero 12 after sync");
	property p_slot_wrap;
		@(posedge clk) disable iff (!srst_n)
		vertical_sync && applied_field_count > 3'h1 && field_slot == 3'(applied_field_count - 3'h1)
		|=> field_slot == 3'h0;
	endproperty
	a_slot_wrap: assert property (p_slot_wrap) else $error("slot did not wrap");
	property p_single;
		@(posedge clk) disable iff (!srst_n)
		vertical_sync && applied_field_count == 3'h1 |=> field_slot == 3'h0;
	endproperty
	a_single: assert property (p_single) else $error("single field moved slot");
	property p_clamp_mask;
		@(posedge clk) disable iff (!srst_n)
		clamp_masked |=> !black_clamp_pulse;
	endproperty
	a_clamp_mask: assert property (p_clamp_mask) else $error("clamp on masked line");
	property p_blank_mask;
		@(posedge clk) disable iff (!srst_n)
		blank_masked |=> !pixel_blank_pulse;
	endproperty
	a_blank_mask: assert property (p_blank_mask) else $error("blank on masked line");
	property p_region;
		@(posedge clk) disable iff (!srst_n)
		1'b1 |=> region_index == $past(region_c);
	endproperty
	a_region: assert property (p_region) else $error("region index stale");
	property p_vsync_line;
		@(posedge clk) disable iff (!srst_n)
		vertical_sync |=> line_count == 13'h0000;
	endproperty
	a_vsync_line: assert property (p_vsync_line) else $error("line not cleared on vsync");
	property p_base;
		@(posedge clk) disable iff (!srst_n)
		pattern_base_addr >= 16'h0800;
	endproperty
	a_base: assert property (p_base) else $error("pattern address below base");

	property p_pix_step;
		@(posedge clk) disable iff (!srst_n)
		s_q.hst == cfrs_pkg::CFRS_ST_IDLE
		|=> pixel_count == $past(pixel_count) + 13'h0001;
	endproperty
	a_pix_step: assert property (p_pix_step) else $error("pixel count did not step");

	property p_wait_enter;
		@(posedge clk) disable iff (!srst_n)
		(s_q.hst == cfrs_pkg::CFRS_ST_IDLE) and s_hs_fall
		|=> s_q.hst == cfrs_pkg::CFRS_ST_WAIT && s_q.dly == 4'h1;
	endproperty
	a_wait_enter: assert property (p_wait_enter) else $error("restart wait not entered");

	property p_wait_stay;
		@(posedge clk) disable iff (!srst_n)
		s_q.hst == cfrs_pkg::CFRS_ST_WAIT && s_q.dly != cfrs_pkg::HSYNC_DELAY - 4'h1
		|=> s_q.hst == cfrs_pkg::CFRS_ST_WAIT;
	endproperty
	a_wait_stay: assert property (p_wait_stay) else $error("restart wait left early");

	property p_wait_exit;
		@(posedge clk) disable iff (!srst_n)
		s_q.hst == cfrs_pkg::CFRS_ST_WAIT && s_q.dly == cfrs_pkg::HSYNC_DELAY - 4'h1
		|=> s_q.hst == cfrs_pkg::CFRS_ST_IDLE && pixel_count == 13'h0000;
	endproperty
	a_wait_exit: assert property (p_wait_exit) else $error("restart wait did not end");

	property p_dly_bound;
		@(posedge clk) disable iff (!srst_n)
		s_q.hst == cfrs_pkg::CFRS_ST_WAIT
		|-> s_q.dly < cfrs_pkg::HSYNC_DELAY;
	endproperty
	a_dly_bound: assert property (p_dly_bound) else $error("restart delay overran");

	property p_line_incr;
		@(posedge clk) disable iff (!srst_n)
		s_hs_fall and (!vertical_sync)
		|=> line_count == $past(line_count) + 13'h0001;
	endproperty
	a_line_incr: assert property (p_line_incr) else $error("line did not count");

	property p_line_hold;
		@(posedge clk) disable iff (!srst_n)
		!vertical_sync && !(horizontal_sync == 1'b0 && s_q.hs_prev == 1'b1)
		|=> $stable(line_count);
	endproperty
	a_line_hold: assert property (p_line_hold) else $error("line moved without sync");

	property p_slot_advance;
		@(posedge clk) disable iff (!srst_n)
		vertical_sync && applied_field_count > 3'h1 && field_slot < 3'(applied_field_count - 3'h1)
		|=> field_slot == $past(field_slot) + 3'h1;
	endproperty
	a_slot_advance: assert property (p_slot_advance) else $error("slot did not advance");

	property p_slot_hold;
		@(posedge clk) disable iff (!srst_n)
		!vertical_sync
		|=> $stable(field_slot);
	endproperty
	a_slot_hold: assert property (p_slot_hold) else $error("slot moved without vsync");

	property p_zero_count;
		@(posedge clk) disable iff (!srst_n)
		vertical_sync && applied_field_count == 3'h0
		|=> field_slot == 3'h0;
	endproperty
	a_zero_count: assert property (p_zero_count) else $error("zero field count moved slot");

	property p_slot_range;
		@(posedge clk) disable iff (!srst_n)
		1'b1
		|-> field_slot < 3'(cfrs_pkg::SLOTS);
	endproperty
	a_slot_range: assert property (p_slot_range) else $error("slot beyond last field");

	property p_clamp_pulse;
		@(posedge clk) disable iff (!srst_n)
		!clamp_masked
		|=> black_clamp_pulse == ($past(clamp_toggle_raw) ^ clamp_start_level);
	endproperty
	a_clamp_pulse: assert property (p_clamp_pulse) else $error("clamp polarity wrong");

	property p_blank_pulse;
		@(posedge clk) disable iff (!srst_n)
		!blank_masked
		|=> pixel_blank_pulse == ($past(blank_toggle_raw) ^ blank_start_level);
	endproperty
	a_blank_pulse: assert property (p_blank_pulse) else $error("blank polarity wrong");

	property p_group_stable;
		@(posedge clk) disable iff (!srst_n)
		$stable(region_index)
		|-> $stable(pattern_group);
	endproperty
	a_group_stable: assert property (p_group_stable) else $error("group changed inside region");

	property p_clamp_sel_stable;
		@(posedge clk) disable iff (!srst_n)
		$stable(region_index)
		|-> $stable(clamp_pattern);
	endproperty
	a_clamp_sel_stable: assert property (p_clamp_sel_stable) else $error("clamp selector changed");

	property p_blank_sel_stable;
		@(posedge clk) disable iff (!srst_n)
		$stable(region_index)
		|-> $stable(blank_pattern);
	endproperty
	a_blank_sel_stable: assert property (p_blank_sel_stable) else $error("blank selector changed");

	property p_group_range;
		@(posedge clk) disable iff (!srst_n)
		1'b1
		|-> pattern_base_addr < cfrs_pkg::PATTERN_MEM_BASE + 16'h0020;
	endproperty
	a_group_range: assert property (p_group_range) else $error("pattern address past last group");

	property p_group_overflow;
		@(posedge clk) disable iff (!srst_n)
		pattern_group >= pattern_group_count
		|-> pattern_base_addr == cfrs_pkg::PATTERN_MEM_BASE;
	endproperty
	a_group_overflow: assert property (p_group_overflow) else $error("unstored group addressed");

	property p_region_start;
		@(posedge clk) disable iff (!srst_n)
		s_q.line == cfrs_pkg::LINE_RESET
		|=> region_index == 4'h0;
	endproperty
	a_region_start: assert property (p_region_start) else $error("field did not start in region 0");

	property p_region_max;
		@(posedge clk) disable iff (!srst_n)
		1'b1
		|-> region_index < 4'(NREG);
	endproperty
	a_region_max: assert property (p_region_max) else $error("region index out of range");
endmodule : cfrs_field_region_sequencer

// ==== cfrs_sensor_model.sv ====
// cfrs_sensor_model: sensor side fed by clamp and blank
// assumes: pulses registered on clk
`timescale 1ns/100ps
module cfrs_sensor_model (
	// clock
	input wire logic clk,
	// timing from the sequencer
	input wire logic black_clamp_pulse,
	input wire logic pixel_blank_pulse,
	// cycles where blanking spoils a clamp
	output logic [7:0] overlap_cnt
);
	initial overlap_cnt = 8'h00;
	always @(posedge clk) begin
		if (black_clamp_pulse && pixel_blank_pulse)
			overlap_cnt <= overlap_cnt + 8'h01;
	end
endmodule : cfrs_sensor_model

// ==== cfrs_field_region_sequencer_tb.sv ====
// cfrs_field_region_sequencer_tb: regions, masks, slots, pixel restart
// assumes: cfrs_pkg and the sequencer compiled first
`timescale 1ns/100ps
module cfrs_field_region_sequencer_tb;
	typedef struct packed {
		logic [12:0] line;
		logic raw;
		logic [3:0] rgn;
		logic [4:0] grp;
		logic [15:0] addr;
		logic clamp;
		logic blank;
	} cfrs_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic vs = 1'b0;
	logic hs = 1'b0;
	logic craw = 1'b0;
	logic [2:0] afc = 3'h3;
	logic [116:0] rbl = 117'({13'h0006, 13'h0003, 13'h0000});
	logic [44:0] rps = 45'({5'h05, 5'h1f, 5'h02});
	logic [8:0] csp = 9'h002;
	logic [8:0] cps = 9'h003;
	logic [8:0] bsp = 9'h004;
	logic [8:0] bps = 9'h005;
	logic [38:0] cms = 39'h4;
	logic [38:0] cme = 39'h4;
	logic [38:0] bms = 39'({13'h0007, 26'h0});
	logic [38:0] bme = 39'({13'h0008, 26'h0});
	logic [4:0] pgc = 5'h06;
	logic [34:0] ssg = 35'({5'h09, 5'h11, 5'h04});
	logic braw = 1'b0;
	logic csl_o, cpat_o, bsl_o, bpat_o;
	logic [12:0] line_count, pixel_count;
	logic [3:0] region_index;
	logic [4:0] pattern_group, field_group;
	logic [15:0] pattern_base_addr;
	logic [2:0] field_slot;
	logic black_clamp_pulse, pixel_blank_pulse;
	logic [7:0] overlap_cnt;
	int error_cnt = 0;
	int total_checks = 0;
	int cyc = 0;
	int cur_line = 0;
	// line 4 clamp masked, lines 7-8 blank masked
	cfrs_row_t rows [7] = '{
		'{13'd1, 1'b1, 4'd0, 5'd2, 16'h0802, 1'b1, 1'b0},
		'{13'd3, 1'b0, 4'd1, 5'd31, 16'h0800, 1'b1, 1'b0},
		'{13'd4, 1'b0, 4'd1, 5'd31, 16'h0800, 1'b0, 1'b0},
		'{13'd5, 1'b1, 4'd1, 5'd31, 16'h0800, 1'b0, 1'b0},
		'{13'd6, 1'b0, 4'd2, 5'd5, 16'h0805, 1'b0, 1'b1},
		'{13'd7, 1'b0, 4'd2, 5'd5, 16'h0805, 1'b0, 1'b0},
		'{13'd9, 1'b0, 4'd2, 5'd5, 16'h0805, 1'b0, 1'b1}
	};
	logic [2:0] slot_exp [6] = '{3'h1, 3'h2, 3'h0, 3'h1, 3'h0, 3'h0};
	logic [4:0] grp_exp [6] = '{5'h11, 5'h09, 5'h04, 5'h11, 5'h04, 5'h04};

	cfrs_field_region_sequencer cfrs_field_region_sequencer_inst (
		.clk(clk), .rst_n(rst_n), .vertical_sync(vs), .horizontal_sync(hs),
		.region_boundary_line(rbl), .region_pattern_select(rps),
		.clamp_start_polarity(csp), .clamp_pattern_select(cps),
		.clamp_mask_start(cms), .clamp_mask_end(cme),
		.blank_start_polarity(bsp), .blank_pattern_select(bps),
		.blank_mask_start(bms), .blank_mask_end(bme),
		.pattern_group_count(pgc), .applied_field_count(afc),
		.sequence_slot_group(ssg),
		.clamp_toggle_raw(craw), .blank_toggle_raw(braw),
		.line_count(line_count), .pixel_count(pixel_count), .region_index(region_index),
		.pattern_group(pattern_group), .pattern_base_addr(pattern_base_addr),
		.field_slot(field_slot), .field_group(field_group),
		.clamp_start_level(csl_o), .clamp_pattern(cpat_o), .blank_start_level(bsl_o), .blank_pattern(bpat_o),
		.black_clamp_pulse(black_clamp_pulse), .pixel_blank_pulse(pixel_blank_pulse)
	);

	cfrs_sensor_model cfrs_sensor_model_inst (
		.clk(clk), .black_clamp_pulse(black_clamp_pulse),
		.pixel_blank_pulse(pixel_blank_pulse), .overlap_cnt(overlap_cnt)
	);

	initial begin
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	// one line: sync pulse, then the full restart wait
	task automatic step_line;
		@(posedge clk) hs <= 1'b1;
		@(posedge clk) hs <= 1'b0;
		repeat (12) @(posedge clk);
		#1 chk("pixel_count", 16'(pixel_count), 16'h0000);
		@(posedge clk);
		cur_line++;
	endtask : step_line

	initial begin
		forever @(posedge clk) begin
			cyc++;
			if (cyc == 1000) begin
				error_cnt++;
				tally_and_finish();
			end
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk("line_reset", 16'(line_count), 16'h0000);
		chk("slot_reset", 16'(field_slot), 16'h0000);
		chk("fgroup_reset", 16'(field_group), 16'h0004);
		foreach (rows[i]) begin
			@(posedge clk) craw <= rows[i].raw;
			while (cur_line < int'(rows[i].line)) step_line();
			@(posedge clk);
			#1 chk("region", 16'(region_index), 16'(rows[i].rgn));
			chk("group", 16'(pattern_group), 16'(rows[i].grp));
			chk("addr", pattern_base_addr, rows[i].addr);
			chk("clamp", 16'(black_clamp_pulse), 16'(rows[i].clamp));
			chk("blank", 16'(pixel_blank_pulse), 16'(rows[i].blank));
			chk("clamp_pat", 16'(cpat_o), 16'(cps[rows[i].rgn]));
			chk("blank_pat", 16'(bpat_o), 16'(bps[rows[i].rgn]));
			chk("clamp_lvl", 16'(csl_o), 16'(csp[rows[i].rgn]));
			chk("blank_lvl", 16'(bsl_o), 16'(bsp[rows[i].rgn]));
		end
		foreach (slot_exp[i]) begin
			@(posedge clk) vs <= 1'b1;
			if (i == 4)
				afc <= 3'h1;
			@(posedge clk) vs <= 1'b0;
			repeat (2) @(posedge clk);
			#1 chk("slot", 16'(field_slot), 16'(slot_exp[i]));
			chk("fgroup", 16'(field_group), 16'(grp_exp[i]));
		end
		chk("line_vsync", 16'(line_count), 16'h0000);
		chk("overlap", 16'(overlap_cnt), 16'h0000);
		tally_and_finish();
	end
endmodule : cfrs_field_region_sequencer_tb
